// file: sdc_datapath.sv
// Purpose: Sigma-delta codec digital datapath with APB control
// Assumes: pclk is the internal master clock (master clock pin / divider)
// Notes: Encoder decimates bitstream, decoder interpolates FIFO samples
// Summary of operation
// - Modulator bit is taken once every eight internal clocks.
// - Third-order sinc decimator lowers rate from clock/8 to clock/M.
// - M is 256, 512, 1024, 2048 for 64, 32, 16, 8 kHz.
// - Both filters are sinc cubed with N of 32, 64, 128, 256.
// - Decimator removes shaped noise and yields 15-bit words.
// - Encoder word is 15-bit two's complement, with bit 15 held at zero.
// - Decoder words are 16-bit two's complement, 7FFF top, 8000 bottom.
// - Sinc-cubed interpolator raises decoder rate to clock/8.
// - Host gives one word per period; otherwise previous word reused.
// - Bypass bit 5 of control register E skips the interpolator.
// - Digital modulator turns 16-bit data into bits at clock/8.
// - Input gain code picks 0,6,12,18,20,26,32,38 dB.
// - Output gain code picks +6 dB down to -15 dB in 3 dB steps.
// - Input mux picks differential, loop-back, inverted or single-ended.
// - All rates derive from the internal master clock.
`timescale 1ns/1ps
module sdc_datapath
	import sdc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mod_bit_in,
	output logic dac_bit_out,
	output logic [2:0] input_gain_sel,
	output logic [2:0] output_gain_sel,
	output logic [5:0] input_gain_db,
	output logic signed [5:0] output_gain_db,
	output logic [2:0] input_mux_sel,
	output logic analog_loopback
);
	typedef struct packed {
		logic [7:0] ctrl_d;
		logic [7:0] ctrl_e;
		logic [1:0] rate;
		logic [2:0] div8;
		logic [7:0] sub;
		logic signed [ACC_W-1:0] i1, i2, i3;
		logic signed [ACC_W-1:0] c1, c2, c3;
		logic signed [ACC_W-1:0] d1, d2;
		logic [15:0] enc_word;
		logic enc_new;
		logic [15:0] dec_hold;
		logic signed [ACC_W-1:0] u1, u2;
		logic signed [ACC_W-1:0] v1, v2, v3;
		logic signed [ACC_W-1:0] j1, j2, j3;
		logic signed [17:0] sd_err;
		logic dac_bit;
		logic underrun;
	} sdc_state_type;
	sdc_state_type s_q, s_d;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [15:0] fifo_out_data;
	logic [4:0] fifo_level;
	logic apb_wr, apb_rd;
	logic [7:0] n_last;
	logic frame_tick, bit_tick;
	logic signed [ACC_W-1:0] x, e1, e2, e3, ip;
	logic signed [17:0] sd_in;
	logic [4:0] shr;
	// Sinc filter length minus one for a rate code
	function automatic logic [7:0] sinc_last(input logic [1:0] r);
		case (r)
			2'd0: sinc_last = 8'd31;
			2'd1: sinc_last = 8'd63;
			2'd2: sinc_last = 8'd127;
			default: sinc_last = 8'd255;
		endcase
	endfunction : sinc_last
	// Gain growth of sinc cubed is N^3, i.e. 3*log2(N)
	function automatic logic [4:0] sinc_shift(input logic [1:0] r);
		sinc_shift = 5'(15 + 3 * int'(r));
	endfunction : sinc_shift
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign fifo_pop = frame_tick && fifo_out_valid;
	sdc_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(apb_wr && paddr == ADDR_DEC_DATA),
		.in_ready(fifo_in_ready),
		.in_data(pwdata[15:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);
	always_comb
	begin
		s_d = s_q;
		n_last = sinc_last(s_q.rate);
		shr = sinc_shift(s_q.rate);
		bit_tick = (s_q.div8 == MOD_DIV);
		frame_tick = bit_tick && (s_q.sub == n_last);
		x = mod_bit_in ? 32'sd1 : -32'sd1;
		e1 = '0;
		e2 = '0;
		e3 = '0;
		ip = '0;
		sd_in = '0;
		s_d.enc_new = s_q.enc_new && !(apb_rd && paddr == ADDR_ENC_DATA);
		// Control registers
		if (apb_wr)
		begin
			case (paddr)
				ADDR_CTRL_D: s_d.ctrl_d = pwdata[7:0];
				ADDR_CTRL_E: s_d.ctrl_e = pwdata[7:0];
				ADDR_RATE:
				begin
					s_d.rate = pwdata[1:0];
					s_d.sub = '0;
				end
				ADDR_STATUS: s_d.underrun = s_q.underrun & ~pwdata[1];
				default: s_d.rate = s_q.rate;
			endcase
		end
		s_d.div8 = s_q.div8 + 3'd1;
		if (bit_tick)
		begin
			s_d.sub = (s_q.sub == n_last) ? 8'd0 : s_q.sub + 8'd1;
			// Decimator integrators at clock/8
			s_d.i1 = s_q.i1 + x;
			s_d.i2 = s_q.i2 + s_q.i1;
			s_d.i3 = s_q.i3 + s_q.i2;
			// Interpolator integrators at clock/8
			s_d.v1 = s_q.v1 + s_q.u2;
			s_d.v2 = s_q.v2 + s_q.v1;
			s_d.v3 = s_q.v3 + s_q.v2;
			// First-order error-feedback modulator
			// Zero-stuffed sinc cubed grows by N^2, not N^3
			ip = s_q.v3 >>> (5'd10 + 5'(2 * int'(s_q.rate)));
			if (s_q.ctrl_e[INTERP_BYPASS_BIT])
				sd_in = 18'(signed'(s_q.dec_hold));
			else
				sd_in = ip[17:0];
			s_d.dac_bit = (s_q.sd_err + sd_in) >= 0;
			s_d.sd_err = s_q.sd_err + sd_in
				- (s_d.dac_bit ? 18'sd32768 : -18'sd32768);
		end
		if (frame_tick)
		begin
			// Decimator combs at clock/M
			e1 = s_q.i3 - s_q.c1;
			e2 = e1 - s_q.d1;
			e3 = e2 - s_q.d2;
			s_d.c1 = s_q.i3;
			s_d.d1 = e1;
			s_d.d2 = e2;
			s_d.c3 = e3 >>> (shr - 5'd14);
			// Positive full scale would wrap to the most negative code
			if (s_d.c3 > 32'sd16383)
				s_d.c3 = 32'sd16383;
			s_d.enc_word = {1'b0, s_d.c3[14:0]};
			s_d.enc_new = 1'b1;
			// Decoder sample intake; hold last when host is late
			if (fifo_out_valid)
				s_d.dec_hold = fifo_out_data;
			else
				s_d.underrun = 1'b1;
			// Interpolator combs at clock/M feed zero-stuffing upsampler
			s_d.u1 = 32'(signed'(s_d.dec_hold)) - s_q.j1;
			s_d.j1 = 32'(signed'(s_d.dec_hold));
			s_d.j2 = s_d.u1;
			s_d.j3 = s_d.u1 - s_q.j2;
			s_d.u2 = s_d.j3 - s_q.j3;
		end
		else if (bit_tick)
			s_d.u2 = '0;
	end
	// Gain decoding
	always_comb
	begin
		input_gain_sel = s_q.ctrl_d[IGS_LSB+:3];
		output_gain_sel = s_q.ctrl_d[OGS_LSB+:3];
		if (input_gain_sel[2])
			input_gain_db = 6'd20 + 6'(6 * int'(input_gain_sel[1:0]));
		else
			input_gain_db = 6'(6 * int'(input_gain_sel[1:0]));
		output_gain_db = 6'sd6 - 6'(3 * int'(output_gain_sel));
	end
	assign input_mux_sel = s_q.ctrl_e[2:0];
	assign analog_loopback = s_q.ctrl_e[3];
	assign dac_bit_out = s_q.dac_bit;
	always_comb
	begin
		case (paddr)
			ADDR_CTRL_D: prdata = {24'h00_0000, s_q.ctrl_d};
			ADDR_CTRL_E: prdata = {24'h00_0000, s_q.ctrl_e};
			ADDR_RATE: prdata = {30'h0000_0000, s_q.rate};
			ADDR_ENC_DATA: prdata = {16'h0000, s_q.enc_word};
			ADDR_STATUS: prdata = {26'h000_0000, fifo_level,
				s_q.enc_new};
			ADDR_GAIN: prdata = {20'h0_0000, output_gain_db,
				input_gain_db};
			default: prdata = 32'h0000_0000;
		endcase
		if (!apb_rd)
			prdata = 32'h0000_0000;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.rate <= RATE_RESET;
			s_q.ctrl_d <= CTRL_D_RESET;
			s_q.ctrl_e <= CTRL_E_RESET;
		end
		else
			s_q <= s_d;
	end
endmodule : sdc_datapath

// file: sdc_pkg.sv
// Purpose: Shared constants for the codec datapath
// Assumes: APB register map at 32-bit aligned word offsets
// Notes: Rate code 0..3 selects 64, 32, 16 and 8 kHz
package sdc_pkg;
	localparam logic [7:0] ADDR_CTRL_D = 8'h00;
	localparam logic [7:0] ADDR_CTRL_E = 8'h04;
	localparam logic [7:0] ADDR_RATE = 8'h08;
	localparam logic [7:0] ADDR_DEC_DATA = 8'h0C;
	localparam logic [7:0] ADDR_ENC_DATA = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_GAIN = 8'h18;
	localparam logic [7:0] CTRL_D_RESET = 8'h00;
	localparam logic [7:0] CTRL_E_RESET = 8'h00;
	localparam logic [1:0] RATE_RESET = 2'h3;
	localparam int INTERP_BYPASS_BIT = 5;
	localparam int IGS_LSB = 0;
	localparam int OGS_LSB = 4;
	localparam logic [2:0] MOD_DIV = 3'h7;
	localparam int ACC_W = 32;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 16;
	localparam logic [15:0] POS_FULL = 16'h7FFF;
	localparam logic [15:0] NEG_FULL = 16'h8000;
endpackage : sdc_pkg

// file: sdc_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Flip-flop storage addressed by index
`timescale 1ns/1ps
module sdc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} sdc_fifo_type;
	sdc_fifo_type s_q, s_d;
	logic push, pop;
	always_comb
	begin
		in_ready = (s_q.cnt != DEPTH[AW:0]);
		out_valid = (s_q.cnt != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop)
			s_d.rd = s_q.rd + 1'b1;
		if (push && !pop)
			s_d.cnt = s_q.cnt + 1'b1;
		else if (pop && !push)
			s_d.cnt = s_q.cnt - 1'b1;
	end
	assign out_data = s_q.mem[s_q.rd];
	assign level = s_q.cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule : sdc_fifo

// file: sdc_bitsrc.sv
// Purpose: Far-side model, modulator bit source and DAC bit counter
// Assumes: dens of 0..16 sets ones density in sixteenths
// Notes: Counts DAC ones on every clock
`timescale 1ns/1ps
module sdc_bitsrc (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [4:0] dens,
	input wire logic dac_bit,
	output logic mod_bit,
	output logic [15:0] ones
);
	logic [4:0] acc_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_q <= '0;
			ones <= '0;
		end
		else
		begin
			acc_q <= {1'b0, acc_q[3:0]} + dens;
			ones <= ones + 16'(dac_bit);
		end
	end
	assign mod_bit = acc_q[4];
endmodule : sdc_bitsrc

// file: sdc_datapath_assertions.sv
// Purpose: Port checks of the codec datapath
// Assumes: Bound to sdc_datapath
// Notes: One clock domain
`timescale 1ns/1ps
module sdc_datapath_assertions
	import sdc_pkg::*;
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic dac_bit_out,
	input logic [2:0] input_gain_sel,
	input logic [2:0] output_gain_sel,
	input logic [5:0] input_gain_db,
	input logic signed [5:0] output_gain_db,
	input logic [2:0] input_mux_sel,
	input logic analog_loopback
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence wr_s(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	AST_IGDB: assert property (input_gain_db ==
		(input_gain_sel[2] ? 6'd20 : 6'd0) + 6'd6 * input_gain_sel[1:0])
		else $error("input gain dB wrong");
	AST_OGDB: assert property (
		6'(output_gain_db + 6'd3 * output_gain_sel) == 6'd6)
		else $error("output gain dB wrong");
	AST_IGS: assert property (wr_s(ADDR_CTRL_D) |=>
		input_gain_sel == $past(pwdata[2:0])) else $error("igs not set");
	AST_OGS: assert property (wr_s(ADDR_CTRL_D) |=>
		output_gain_sel == $past(pwdata[6:4])) else $error("ogs not set");
	AST_HOLD: assert property (!(psel && penable && pwrite &&
		paddr == ADDR_CTRL_D) |=> $stable(output_gain_sel))
		else $error("ogs moved");
	AST_MUX: assert property (wr_s(ADDR_CTRL_E) |=>
		{analog_loopback, input_mux_sel} == $past(pwdata[3:0]))
		else $error("mux not set");
	AST_DAC: assert property ($changed(dac_bit_out) |=>
		$stable(dac_bit_out) [*7]) else $error("dac bit too fast");
	AST_RST: assert property ($rose(presetn) |->
		{input_gain_sel, output_gain_sel, analog_loopback, dac_bit_out} == 0)
		else $error("reset defaults wrong");
endmodule : sdc_datapath_assertions
bind sdc_datapath sdc_datapath_assertions chk_u (.*);

// file: tb.sv
// Purpose: Self-checking bench of the codec datapath
// Assumes: Rate code 0 gives 256-clock frames
// Notes: Bit densities judged against half scale
`timescale 1ns/1ps
module tb;
	import sdc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, x;
	logic pready, pslverr, mod_bit_in, dac_bit_out, analog_loopback;
	logic [2:0] input_gain_sel, output_gain_sel, input_mux_sel;
	logic [5:0] input_gain_db;
	logic signed [5:0] output_gain_db;
	logic [4:0] dens = 0;
	logic [15:0] ones, o;
	int seed = 1830, failures = 0, compares = 0;
	sdc_datapath dut_u (.*);
	sdc_bitsrc src_u (.pclk(pclk), .presetn(presetn), .dens(dens),
		.dac_bit(dac_bit_out), .mod_bit(mod_bit_in), .ones(ones));
	initial forever #10 pclk = ~pclk;
	task report_and_stop;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		if (pready !== 1'b1)
		begin
			failures++;
			report_and_stop();
		end
		{psel, penable} <= 2'b00;
		#1;
	endtask : apb
	function automatic logic [5:0] igdb(input logic [2:0] c);
		return (c[2] ? 6'd20 : 6'd0) + 6'd6 * c[1:0];
	endfunction : igdb
	task dac_level(input logic [31:0] v, input logic hi);
		apb(1, ADDR_DEC_DATA, v);
		repeat (2048) @(posedge pclk);
		o = ones;
		repeat (1024) @(posedge pclk);
		chk(16'(ones - o) > 512, hi);
	endtask : dac_level
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		#1;
		chk(6'(output_gain_db), 6'(6));
		apb(0, ADDR_RATE, 0);
		chk(r[1:0], RATE_RESET);
		apb(0, 8'hFC, 0);
		chk(r, 0);
		for (int i = 0; i < 8; i++)
		begin
			x = $random(seed);
			apb(1, ADDR_CTRL_D, {25'b0, 3'(7 - i), 1'b0, 3'(i)});
			chk(input_gain_db, igdb(3'(i)));
			chk(6'(output_gain_db), 6'(6 - 3 * (7 - i)));
			apb(1, ADDR_CTRL_E, x & 32'h0000_002F);
			chk({analog_loopback, input_mux_sel}, x[3:0]);
			apb(0, ADDR_CTRL_E, 0);
			chk(r[5], x[5]);
		end
		apb(1, ADDR_RATE, 0);
		for (int k = 0; k < 2; k++)
		begin
			dens <= k ? 5'd0 : 5'd16;
			repeat (1024) @(posedge pclk);
			apb(0, ADDR_STATUS, 0);
			chk(r[0], 1);
			apb(0, ADDR_ENC_DATA, 0);
			chk(r[15:14], k ? 2'b01 : 2'b00);
			apb(0, ADDR_STATUS, 0);
			chk(r[0], 0);
		end
		for (int b = 1; b >= 0; b--)
		begin
			apb(1, ADDR_CTRL_E, 32'(b) << INTERP_BYPASS_BIT);
			dac_level(NEG_FULL, 0);
			dac_level(POS_FULL, 1);
		end
		// Fill right after a frame so no pop lands mid-fill
		apb(0, ADDR_ENC_DATA, 0);
		r = 0;
		for (int w = 0; w < 300 && r[0] !== 1'b1; w++)
			apb(0, ADDR_STATUS, 0);
		chk(r[0], 1);
		chk(pslverr, 0);
		for (int i = 0; i < 17; i++)
			apb(1, ADDR_DEC_DATA, NEG_FULL);
		apb(0, ADDR_STATUS, 0);
		chk(r[5:1], FIFO_DEPTH);
		repeat (4608) @(posedge pclk);
		apb(0, ADDR_STATUS, 0);
		chk(r[5:1], 0);
		dac_level(NEG_FULL, 0);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, ADDR_CTRL_D, 0);
		chk(r, 0);
		report_and_stop();
	end
endmodule : tb
